// [include/dac_cmp_pkg.sv]
package dac_cmp_pkg;

  // ==========================================================
  // Register map
  localparam logic [3:0] ADDR_REF_CONTROL_0 = 4'h0;
  localparam logic [3:0] ADDR_REF_LEVEL_SELECT = 4'h1;
  localparam logic [3:0] ADDR_CMP1_CONTROL_0 = 4'h2;
  localparam logic [3:0] ADDR_CMP1_CONTROL_1 = 4'h3;
  localparam logic [3:0] ADDR_CMP2_CONTROL_0 = 4'h4;
  localparam logic [3:0] ADDR_CMP2_CONTROL_1 = 4'h5;
  localparam logic [3:0] ADDR_CMP_RESULT_SUMMARY = 4'h6;
  localparam logic [3:0] ADDR_CMP_EDGE_FLAGS = 4'h7;

  // ==========================================================
  // Field positions
  localparam int REF_ON_BIT = 7;
  localparam int REF_PIN1_BIT = 5;
  localparam int REF_PIN2_BIT = 4;
  localparam int REF_UPPER_BIT = 2;
  localparam int CMP_ON_BIT = 7;
  localparam int CMP_RESULT_BIT = 6;
  localparam int CMP_PIN_BIT = 5;
  localparam int CMP_INVERT_BIT = 4;
  localparam int CMP_SPEED_BIT = 2;
  localparam int CMP_HYST_BIT = 1;
  localparam int CMP_SYNC_BIT = 0;
  localparam int CMP_RISE_BIT = 7;
  localparam int CMP_FALL_BIT = 6;

  // ==========================================================
  // Writable masks and reset values
  localparam logic [7:0] REF_CONTROL_0_MASK = 8'hB4;
  localparam logic [7:0] REF_LEVEL_MASK = 8'h1F;
  localparam logic [7:0] CMP_CONTROL_0_MASK = 8'hB7;
  localparam logic [7:0] CMP_CONTROL_1_MASK = 8'hF7;
  localparam logic [7:0] REF_CONTROL_0_RESET = 8'h00;
  localparam logic [7:0] REF_LEVEL_RESET = 8'h00;
  localparam logic [7:0] CMP_CONTROL_0_RESET = 8'h04;
  localparam logic [7:0] CMP_CONTROL_1_RESET = 8'h00;
  localparam int NUM_CMP = 2;

  // Analog switch settings for one comparator
  typedef struct packed {
    logic [3:0] plus_route;  // One-hot: pin, ref gen, fixed ref, ground
    logic [4:0] minus_route; // One-hot over the minus sources
    logic powered;
    logic fast;
    logic hyst;
  } cmp_analog_t;

  // Reference generator settings
  typedef struct packed {
    logic on;
    logic upper_ext;
    logic pin1;
    logic pin2;
    logic [4:0] level;
  } ref_analog_t;

  // Register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

endpackage

// [hw/dac_and_comparator_control.sv]
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps
module dac_and_comparator_control
  import dac_cmp_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic instr_cycle,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [1:0] cmp_raw_pin,
  input wire logic timer_clk_pin,
  input wire logic [1:0] ref_pin_in,
  input wire logic [1:0] ref_pin_latch,
  input wire logic [1:0] cmp_pin_latch,
  input wire logic [1:0] cmp_pin_direction,
  output ref_analog_t ref_analog,
  output cmp_analog_t cmp1_analog,
  output cmp_analog_t cmp2_analog,
  output logic [1:0] ref_pin_out,
  output logic [1:0] ref_pin_oe_n,
  output logic [1:0] ref_pin_pullup,
  output logic [1:0] ref_pin_input_en,
  output logic [1:0] ref_pin_read,
  output logic [1:0] cmp_pin_out,
  output logic [1:0] cmp_pin_oe_n,
  output logic [1:0] cmp_result_synced,
  output logic [1:0] cmp_result_unsynced,
  output logic [1:0] cmp_edge_flag
);

  // ==========================================================
  // Register layout
  // Offset 0, reference_control_0:
  //   Bit 7 turns the ladder on
  //   Bit 5 puts the level on pin one
  //   Bit 4 puts the level on pin two
  //   Bit 2 picks the external pin as the upper end
  //   Other bits are not kept and read as zero
  // Offset 1, reference_level_select:
  //   Bits 4 to 0 hold the level code
  //   Bits 7 to 5 are not kept and read as zero
  // Offsets 2 and 4, first control word of each comparator:
  //   Bit 7 turns the comparator on
  //   Bit 6 shows the latched result, writes to it are dropped
  //   Bit 5 hands the pin to the comparator
  //   Bit 4 inverts the result
  //   Bit 2 selects the faster, hungrier setting
  //   Bit 1 asks for hysteresis
  //   Bit 0 takes the result at timer clock falling edges
  // Offsets 3 and 5, second control word of each comparator:
  //   Bit 7 lets a rising result set the edge flag
  //   Bit 6 lets a falling result set the edge flag
  //   Bits 5 and 4 pick the plus source
  //   Bits 2 to 0 pick the minus source
  // Offset 6, result summary: bit 0 first, bit 1 second comparator
  // Offset 7, edge flags: a written one clears that flag
  // Unmapped offsets read zero and ignore writes

  // ==========================================================
  // Timing
  // Every register write lands on the edge that samples it.
  // The analog controls follow one edge later, since they are
  // registered outputs; the switches see a clean, glitch-free word.
  // Read data are registered as well and stand for one cycle only;
  // in every other cycle the read bus carries zero, so an OR of
  // several slaves on one bus stays safe.
  // The raw compare pins are asynchronous to this clock and pass
  // two flops first, so a result reaches the outputs three edges
  // after the pin moves. Short pulses below one cycle may be lost;
  // that is the price of a metastability-safe path.
  // The timer clock pin is synchronised the same way; its falling
  // edge is found from the second stage and one more flop, so a
  // timer clock faster than half of this clock is not seen.
  // The internal result is latched on the instruction strobe, so
  // software reads a value that cannot change within one instruction.
  // Edge flags follow the latched copy, not the raw one, which keeps
  // a noisy input from setting a flag software would never see.

  // ==========================================================
  // Pin handling
  // A reference pin that carries the level must not fight the
  // ladder: its driver is held off, its pull-up and its input
  // detector are turned off, and a port read returns zero.
  // When a reference pin is not carrying the level, its driver
  // follows the port latch as before.
  // The digital level of a reference pin is synchronised before it
  // reaches the read path, since the pin may move at any time.
  // A comparator pin is driven only with the drive bit set, the
  // direction set to output and the comparator on. The drive bit
  // alone decides whose value is offered to the pin; the port latch
  // shows only while the drive bit is clear.

  // ==========================================================
  // Limitations
  // The ladder itself, the comparators and the switches are analog;
  // this block only hands them settings.
  // Sleep is not a reset here: nothing clears the registers on wake,
  // so software should turn the ladder off before sleep to save power.
  // Reserved minus codes connect nothing, which leaves the inverting
  // input floating; software should avoid them.
  // Clock enable low freezes every register, bus writes included;
  // a write held while it is low is simply not taken.
  // Reset wins over clock enable, so a frozen block still resets.

  // ==========================================================
  // State
  typedef struct packed {
    logic [7:0] ref_ctrl;
    logic [7:0] ref_level;
    logic [1:0][7:0] ctrl0;
    logic [1:0][7:0] ctrl1;
    logic [1:0] raw_s1;
    logic [1:0] raw_s2;
    logic tclk_s1;
    logic tclk_s2;
    logic tclk_prev;
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    logic [1:0] latched;
    logic [1:0] sync_hold;
    logic [1:0] prev_result;
    logic [1:0] flags;
    logic [7:0] rdata;
    ref_analog_t ref_analog;
    cmp_analog_t [1:0] cmp_analog;
    logic [1:0] ref_pin_oe_n;
    logic [1:0] ref_pin_pullup;
    logic [1:0] ref_pin_input_en;
    logic [1:0] ref_pin_read;
    logic [1:0] cmp_pin_out;
    logic [1:0] cmp_pin_oe_n;
    logic [1:0] synced;
    logic [1:0] unsynced;
  } state_t;

  state_t state;
  state_t next_state;

  // One-hot plus routing; empty when the comparator is off
  function automatic logic [3:0] plus_route(input logic on, input logic [1:0] sel);
    plus_route = on ? (4'h1 << sel) : 4'h0;
  endfunction

  // One-hot minus routing; reserved codes connect nothing
  function automatic logic [4:0] minus_route(input logic on, input logic [2:0] sel);
    minus_route = (on && sel <= 3'h4) ? (5'h01 << sel) : 5'h00;
  endfunction

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic tclk_fall;
    logic [1:0] result;
    logic [1:0] pin_value;
    logic [1:0] set_flags;
    next_state = state;
    tclk_fall = state.tclk_prev && !state.tclk_s2;
    result = '0;
    pin_value = '0;
    set_flags = '0;

    // Pin inputs pass two flops; only the second stage is read, and for the timer clock also its third flop
    next_state.raw_s1 = cmp_raw_pin;
    next_state.raw_s2 = state.raw_s1;
    next_state.tclk_s1 = timer_clk_pin;
    next_state.tclk_s2 = state.tclk_s1;
    next_state.tclk_prev = state.tclk_s2;
    next_state.pin_s1 = ref_pin_in;
    next_state.pin_s2 = state.pin_s1;

    for (int i = 0; i < NUM_CMP; i++) begin
      // Raw compare is high when plus exceeds minus, then polarity applied
      result[i] = state.raw_s2[i] ^ state.ctrl0[i][CMP_INVERT_BIT];
      // Internal copy latched once per instruction cycle
      if (instr_cycle) begin
        next_state.latched[i] = result[i];
      end
      // Sync mode holds the value taken at the timer clock falling edge
      if (tclk_fall) begin
        next_state.sync_hold[i] = result[i];
      end
      pin_value[i] = state.ctrl0[i][CMP_SYNC_BIT] ? state.sync_hold[i] : result[i];
      next_state.synced[i] = pin_value[i];
      next_state.unsynced[i] = result[i];
      // Drive bit owns the pin; the latch value shows only when the drive bit is clear
      next_state.cmp_pin_out[i] = state.ctrl0[i][CMP_PIN_BIT] ? pin_value[i]
                                                              : cmp_pin_latch[i];
      next_state.cmp_pin_oe_n[i] = !(state.ctrl0[i][CMP_PIN_BIT]
                                    && !cmp_pin_direction[i]
                                    && state.ctrl0[i][CMP_ON_BIT]);
      // Edge detection on the latched result; a polarity flip also counts
      next_state.prev_result[i] = state.latched[i];
      set_flags[i] = (state.ctrl1[i][CMP_RISE_BIT] && state.latched[i]
                      && !state.prev_result[i])
                     || (state.ctrl1[i][CMP_FALL_BIT] && !state.latched[i]
                         && state.prev_result[i]);
      next_state.cmp_analog[i].plus_route = plus_route(state.ctrl0[i][CMP_ON_BIT],
                                                       state.ctrl1[i][5:4]);
      next_state.cmp_analog[i].minus_route = minus_route(state.ctrl0[i][CMP_ON_BIT],
                                                         state.ctrl1[i][2:0]);
      next_state.cmp_analog[i].powered = state.ctrl0[i][CMP_ON_BIT];
      next_state.cmp_analog[i].fast = state.ctrl0[i][CMP_SPEED_BIT];
      next_state.cmp_analog[i].hyst = state.ctrl0[i][CMP_HYST_BIT];
    end

    // Reference ladder controls; the code sets the tap, code over 32 of the span
    next_state.ref_analog.on = state.ref_ctrl[REF_ON_BIT];
    next_state.ref_analog.upper_ext = state.ref_ctrl[REF_UPPER_BIT];
    next_state.ref_analog.pin1 = state.ref_ctrl[REF_PIN1_BIT];
    next_state.ref_analog.pin2 = state.ref_ctrl[REF_PIN2_BIT];
    next_state.ref_analog.level = state.ref_level[4:0];

    // A pin carrying the level loses its digital functions
    for (int p = 0; p < 2; p++) begin
      logic carry;
      carry = (p == 0) ? state.ref_ctrl[REF_PIN1_BIT] : state.ref_ctrl[REF_PIN2_BIT];
      next_state.ref_pin_oe_n[p] = carry ? 1'b1 : ref_pin_latch[p];
      next_state.ref_pin_pullup[p] = !carry;
      next_state.ref_pin_input_en[p] = !carry;
      next_state.ref_pin_read[p] = carry ? 1'b0 : state.pin_s2[p];
    end

    // Read path, data in the following cycle
    next_state.rdata = 8'h00;
    if (rd) begin
      if (addr == ADDR_REF_CONTROL_0) begin
        next_state.rdata = state.ref_ctrl;
      end else if (addr == ADDR_REF_LEVEL_SELECT) begin
        next_state.rdata = state.ref_level;
      end else if (addr == ADDR_CMP1_CONTROL_0 || addr == ADDR_CMP2_CONTROL_0) begin
        next_state.rdata = state.ctrl0[addr[2]] & CMP_CONTROL_0_MASK;
        next_state.rdata[CMP_RESULT_BIT] = state.latched[addr[2]];
      end else if (addr == ADDR_CMP1_CONTROL_1 || addr == ADDR_CMP2_CONTROL_1) begin
        next_state.rdata = state.ctrl1[addr[2]];
      end else if (addr == ADDR_CMP_RESULT_SUMMARY) begin
        next_state.rdata = {6'h00, state.latched};
      end else if (addr == ADDR_CMP_EDGE_FLAGS) begin
        next_state.rdata = {6'h00, state.flags};
      end
    end

    // Flags: writing one clears, a new edge in the same cycle wins
    next_state.flags = state.flags;
    if (wr && addr == ADDR_CMP_EDGE_FLAGS) begin
      next_state.flags = state.flags & ~wdata[1:0];
    end
    next_state.flags = next_state.flags | set_flags;

    // Writes land on the next edge; masks keep unused bits at zero
    if (wr) begin
      if (addr == ADDR_REF_CONTROL_0) begin
        next_state.ref_ctrl = wdata & REF_CONTROL_0_MASK;
      end else if (addr == ADDR_REF_LEVEL_SELECT) begin
        next_state.ref_level = wdata & REF_LEVEL_MASK;
      end else if (addr == ADDR_CMP1_CONTROL_0 || addr == ADDR_CMP2_CONTROL_0) begin
        next_state.ctrl0[addr[2]] = wdata & CMP_CONTROL_0_MASK;
      end else if (addr == ADDR_CMP1_CONTROL_1 || addr == ADDR_CMP2_CONTROL_1) begin
        next_state.ctrl1[addr[2]] = wdata & CMP_CONTROL_1_MASK;
      end
    end
  end

  // ==========================================================
  // Registers; sleep wake is not a reset, so the registers keep contents
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= '0;
      state.ref_ctrl <= REF_CONTROL_0_RESET;
      state.ref_level <= REF_LEVEL_RESET;
      state.ctrl0 <= {CMP_CONTROL_0_RESET, CMP_CONTROL_0_RESET};
      state.ctrl1 <= {CMP_CONTROL_1_RESET, CMP_CONTROL_1_RESET};
      state.ref_pin_oe_n <= 2'h3;
      state.ref_pin_pullup <= 2'h3;
      state.ref_pin_input_en <= 2'h3;
      state.cmp_pin_oe_n <= 2'h3;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Outputs straight from flops; ref_pin_out is tied to zero
  assign rdata = state.rdata;
  assign ref_analog = state.ref_analog;
  assign cmp1_analog = state.cmp_analog[0];
  assign cmp2_analog = state.cmp_analog[1];
  assign ref_pin_out = 2'h0;
  assign ref_pin_oe_n = state.ref_pin_oe_n;
  assign ref_pin_pullup = state.ref_pin_pullup;
  assign ref_pin_input_en = state.ref_pin_input_en;
  assign ref_pin_read = state.ref_pin_read;
  assign cmp_pin_out = state.cmp_pin_out;
  assign cmp_pin_oe_n = state.cmp_pin_oe_n;
  assign cmp_result_synced = state.synced;
  assign cmp_result_unsynced = state.unsynced;
  assign cmp_edge_flag = state.flags;

endmodule

// [verif/dac_cmp_checker.sv]
`timescale 1ns/1ps
module dac_cmp_checker
  import dac_cmp_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic [1:0] cmp_raw_pin,
  input wire logic [1:0] cmp_pin_direction,
  input wire ref_analog_t ref_analog,
  input wire cmp_analog_t cmp1_analog,
  input wire cmp_analog_t cmp2_analog,
  input wire logic [1:0] ref_pin_oe_n,
  input wire logic [1:0] ref_pin_pullup,
  input wire logic [1:0] ref_pin_input_en,
  input wire logic [1:0] ref_pin_read,
  input wire logic [1:0] cmp_pin_oe_n,
  input wire logic [1:0] cmp_result_unsynced
);
  // ==========================================================
  // Timing and shadow state
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic inv1;
  // Shadow of the invert bit, so polarity is judged without a bus read
  always_ff @(posedge clk) begin
    if (reset) begin
      inv1 <= 1'b0;
    end else if (clk_en && wr && addr == ADDR_CMP1_CONTROL_0) begin
      inv1 <= wdata[CMP_INVERT_BIT];
    end
  end
  sequence wr_s(a);
    clk_en && wr && addr == a ##1 clk_en;
  endsequence
  sequence steady_s;
    clk_en && cmp1_analog.powered && $stable(cmp_raw_pin[0]) && $stable(inv1);
  endsequence
  // ==========================================================
  // Properties
  ref_ctrl_follow_a: assert property (wr_s(ADDR_REF_CONTROL_0) |-> ##1
    {ref_analog.on, ref_analog.pin1, ref_analog.pin2, ref_analog.upper_ext} ==
    $past({wdata[7], wdata[5], wdata[4], wdata[2]}, 2)) else $error("ref control not applied");
  level_follow_a: assert property (wr_s(ADDR_REF_LEVEL_SELECT) |-> ##1
    ref_analog.level == $past(wdata[4:0], 2)) else $error("level code not applied");
  pin_override_a: assert property (ref_analog.pin1 |-> ref_pin_oe_n[0] &&
    !ref_pin_pullup[0] && !ref_pin_input_en[0] && !ref_pin_read[0]) else $error("pin not released");
  rdata_idle_a: assert property (!(rd && clk_en) |=> rdata == 8'h00)
    else $error("read data outside read slot");
  cmp1_off_a: assert property (!cmp1_analog.powered |-> {cmp1_analog.plus_route,
    cmp1_analog.minus_route} == 9'h000) else $error("cmp1 inputs connected while off");
  cmp2_off_a: assert property (!cmp2_analog.powered |-> {cmp2_analog.plus_route,
    cmp2_analog.minus_route} == 9'h000) else $error("cmp2 inputs connected while off");
  pin_gate_a: assert property (!cmp_pin_oe_n[0] |-> !$past(cmp_pin_direction[0]) &&
    cmp1_analog.powered) else $error("cmp pin driven without all conditions");
  polarity_a: assert property (steady_s[*4] |->
    cmp_result_unsynced[0] == (cmp_raw_pin[0] ^ inv1)) else $error("cmp1 result wrong");
  reset_state_a: assert property ($past(reset) |-> ref_analog == 9'h000 &&
    ref_pin_oe_n == 2'h3 && cmp_pin_oe_n == 2'h3) else $error("state after reset wrong");
endmodule
bind dac_and_comparator_control dac_cmp_checker u_dac_cmp_checker (.*);

// [verif/test_dac_and_comparator_control.sv]
`timescale 1ns/1ps
module test_dac_and_comparator_control;
  import dac_cmp_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic instr_cycle = 1'b0;
  logic [1:0] ic_cnt = 2'h0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [1:0] cmp_raw_pin = 2'h0;
  logic timer_clk_pin = 1'b0;
  logic [1:0] ref_pin_in = 2'h3;
  logic [1:0] ref_pin_latch = 2'h0;
  logic [1:0] cmp_pin_latch = 2'h0;
  logic [1:0] cmp_pin_direction = 2'h0;
  logic [7:0] rdata;
  ref_analog_t ref_analog;
  cmp_analog_t cmp1_analog;
  cmp_analog_t cmp2_analog;
  logic [1:0] ref_pin_out, ref_pin_oe_n, ref_pin_pullup, ref_pin_input_en, ref_pin_read;
  logic [1:0] cmp_pin_out, cmp_pin_oe_n, cmp_result_synced, cmp_result_unsynced, cmp_edge_flag;
  int n_fail = 0;
  int comparisons = 0;
  logic [3:0] a;
  logic [7:0] d;
  logic e;
  // ==========================================================
  // Clock, instruction strobe, design
  always #4 clk = ~clk;
  dac_and_comparator_control u_dac_and_comparator_control (.*);
  // One pulse in four clocks, so latching is seen at a slower rate
  always @(posedge clk) begin
    ic_cnt <= ic_cnt + 2'h1;
    instr_cycle <= (ic_cnt == 2'h3);
  end
  // ==========================================================
  // Tasks and expectations
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] ad, input logic [7:0] dt);
    @(posedge clk);
    addr <= ad;
    wdata <= dt;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] ad, input logic [7:0] exp, input logic [7:0] keep);
    @(posedge clk);
    addr <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    check(rdata & keep, exp);
  endtask
  task automatic settle();
    repeat (12) @(posedge clk);
    @(negedge clk);
  endtask
  function automatic logic [7:0] mask_of(input logic [3:0] ad);
    case (ad)
      ADDR_REF_CONTROL_0: return REF_CONTROL_0_MASK;
      ADDR_REF_LEVEL_SELECT: return REF_LEVEL_MASK;
      ADDR_CMP1_CONTROL_0, ADDR_CMP2_CONTROL_0: return CMP_CONTROL_0_MASK;
      ADDR_CMP1_CONTROL_1, ADDR_CMP2_CONTROL_1: return CMP_CONTROL_1_MASK;
      default: return 8'h00;
    endcase
  endfunction
  task automatic stop_test();
    if (n_fail == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // A hang costs a mismatch and still reaches the verdict
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    stop_test();
  end
  // ==========================================================
  // Scenarios
  initial begin
    void'($urandom(32'h33b30976));
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      rd_reg(4'(i), (i == 2 || i == 4) ? CMP_CONTROL_0_RESET : 8'h00, 8'hFF);
    end
    // Random writes, each shadowed by a write to an unmapped place
    repeat (30) begin
      a = 4'($urandom_range(0, 5));
      d = 8'($urandom);
      wr_reg(a, d);
      wr_reg(4'h9, ~d);
      rd_reg(a, d & mask_of(a) & 8'hBF, 8'hBF);
      if (a == 4'h0) begin
        check(8'(ref_analog[8:5]), 8'({d[7], d[2], d[5:4]}));
      end
      if (a == 4'h1) check(8'(ref_analog.level), d & 8'h1F);
    end
    wr_reg(ADDR_REF_CONTROL_0, 8'hA0);
    settle();
    check(8'({ref_pin_read[0], ref_pin_oe_n[0]}), 8'h01);
    check(8'({ref_pin_pullup[0], ref_pin_input_en[0]}), 8'h00);
    check(8'(ref_pin_read[1]), 8'h01);
    // Polarity table on both comparators; the result toggles, arming the edge flags
    for (int i = 0; i < 2; i++) begin
      for (int k = 0; k < 4; k++) begin
        @(posedge clk);
        cmp_raw_pin[i] <= k[0];
        e = k[0] ^ k[1];
        wr_reg(4'(2 + 2 * i), 8'h84 | (k[1] ? 8'h10 : 8'h00));
        wr_reg(4'(3 + 2 * i), 8'hC0);
        settle();
        rd_reg(4'(2 + 2 * i), 8'h84 | (k[1] ? 8'h10 : 8'h00) | (e ? 8'h40 : 8'h00), 8'hFF);
        rd_reg(ADDR_CMP_RESULT_SUMMARY, 8'(e) << i, 8'h01 << i);
        check(8'({cmp_result_synced[i], cmp_result_unsynced[i]}), e ? 8'h03 : 8'h00);
      end
    end
    check(8'(cmp_edge_flag), 8'h03);
    wr_reg(ADDR_CMP1_CONTROL_1, 8'h00);
    wr_reg(ADDR_CMP2_CONTROL_1, 8'h00);
    wr_reg(ADDR_CMP_EDGE_FLAGS, 8'h03);
    @(posedge clk);
    cmp_raw_pin <= ~cmp_raw_pin;
    settle();
    check(8'(cmp_edge_flag), 8'h00);
    // Every plus code and every defined minus code
    wr_reg(ADDR_CMP1_CONTROL_0, 8'h84);
    for (int s = 0; s < 5; s++) begin
      wr_reg(ADDR_CMP1_CONTROL_1, 8'((s % 4) << 4) | 8'(s));
      settle();
      check(8'(cmp1_analog.plus_route), 8'h01 << (s % 4));
      check(8'(cmp1_analog.minus_route), 8'h01 << s);
    end
    wr_reg(ADDR_CMP1_CONTROL_0, 8'h04);
    settle();
    check(8'(cmp1_analog.powered), 8'h00);
    check(8'(cmp1_analog.plus_route), 8'h00);
    check(8'(cmp1_analog.minus_route), 8'h00);
    // Pin drive needs drive bit, output direction and comparator on together
    for (int g = 0; g < 8; g++) begin
      @(posedge clk);
      cmp_pin_direction[0] <= g[2];
      wr_reg(ADDR_CMP1_CONTROL_0, 8'h04 | (g[0] ? 8'h80 : 8'h00) | (g[1] ? 8'h20 : 8'h00));
      settle();
      check(8'(cmp_pin_oe_n[0]), (g[0] && g[1] && !g[2]) ? 8'h00 : 8'h01);
    end
    // Sync mode holds the result until a timer clock falling edge
    @(posedge clk);
    cmp_raw_pin[0] <= 1'b1;
    timer_clk_pin <= 1'b1;
    wr_reg(ADDR_CMP1_CONTROL_0, 8'hA5);
    settle();
    check(8'({cmp_result_synced[0], cmp_pin_out[0], cmp_result_unsynced[0]}), 8'h01);
    @(posedge clk);
    timer_clk_pin <= 1'b0;
    settle();
    check(8'({cmp_result_synced[0], cmp_pin_out[0], cmp_result_unsynced[0]}), 8'h07);
    // Drive bit clear gives the pin back to the port latch
    @(posedge clk);
    cmp_pin_latch <= 2'h1;
    wr_reg(ADDR_CMP1_CONTROL_0, 8'h84);
    settle();
    check(8'(cmp_pin_out[0]), 8'h01);
    // Reset in mid-run clears the reference settings
    wr_reg(ADDR_REF_LEVEL_SELECT, 8'h1F);
    wr_reg(ADDR_REF_CONTROL_0, 8'hB4);
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    rd_reg(ADDR_REF_LEVEL_SELECT, 8'h00, 8'hFF);
    rd_reg(ADDR_REF_CONTROL_0, 8'h00, 8'hFF);
    stop_test();
  end
endmodule
